// File: hdl/sps_status_protect.sv
// SPI serial EEPROM front end: bit timing, status register and write protection.
// Assumes SPI pins are asynchronous and sampled by clk, at least 8 clk per SCK period.
// Functional notes
// - Serial input sampled on rising SCK, most significant bit first.
// - Serial output changes on falling SCK, most significant bit first.
// - Block-guard bits change only by status store and persist across power loss.
// - Write latch set by enable command, cleared by disable, at the end of each write cycle and at power loss.
// - Busy flag follows internal write cycle only, never set by a command.
// - Read-status returns all eight status bits.
// - Status byte: honour bit 7, zeros 6..4, guards 3..2, latch 1, busy 0.
// - Protect pin ignored when honour bit is 0, obeyed when 1.
// - Array write and status store refused while write latch is 0.
// - Busy reads 1 during a write cycle, 0 otherwise.
// - Guard code 00 none, 01 top quarter, 10 upper half, 11 everything.
// - Status store rejected while protect pin low and honoured.
// - A running write cycle completes even if protection is asserted.
`timescale 1ns/1ps
`default_nettype none
module sps_status_protect
  import sps_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             sck,
  input  wire logic             si,
  input  wire logic             chip_select_n,
  input  wire logic             protect_pin_n,
  output logic                  so_out,
  output logic                  so_oe_n,
  input  wire logic [2:0]       nv_init,
  output logic                  nv_save,
  output logic [2:0]            nv_save_bits,
  output logic                  arr_valid,
  input  wire logic             arr_ready,
  output sps_word_t             arr_word
);
  // Every assertion below shares the one clock and holds off during reset
  default clocking cb_a @(posedge clk); endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [2:0] sck_sy_reg, cs_sy_reg;
  logic [1:0] si_sy_reg, wp_sy_reg;

  // Two flops each; the third sck/cs flop only serves the edge finder
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sck_sy_reg <= 3'h0;
      cs_sy_reg  <= 3'h7;
      si_sy_reg  <= 2'h0;
      wp_sy_reg  <= 2'h3;
    end else begin
      sck_sy_reg <= {sck_sy_reg[1:0], sck};
      cs_sy_reg  <= {cs_sy_reg[1:0], chip_select_n};
      si_sy_reg  <= {si_sy_reg[0], si};
      wp_sy_reg  <= {wp_sy_reg[0], protect_pin_n};
    end
  end

  wire cs_act   = ~cs_sy_reg[1];
  wire sck_rise = sck_sy_reg[1] & ~sck_sy_reg[2] & cs_act;
  wire sck_fall = ~sck_sy_reg[1] & sck_sy_reg[2] & cs_act;
  wire cs_rise  = cs_sy_reg[1] & ~cs_sy_reg[2];
  wire si_s     = si_sy_reg[1];
  wire wp_low   = ~wp_sy_reg[1];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  sps_state_t        state_reg;
  sps_state_t        state_next;
  logic [2:0]        bit_cnt_reg;
  logic [7:0]        shin_reg;
  logic [7:0]        cmd_reg;
  logic [7:0]        out_sh_reg;
  logic              so_reg;
  logic              addr_cnt_reg;
  logic [15:0]       addr_reg;
  logic              data_got_reg, stat_got_reg;
  logic [7:0]        stat_new_reg;
  logic              honour_reg, guard_hi_reg, guard_lo_reg;
  logic              latch_reg, busy_reg, nv_load_reg, nv_save_reg;
  logic [31:0]       timer_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Guarded ranges by the two guard bits
  function automatic logic guarded(input logic [ADDR_W-1:0] a, input logic [1:0] g);
    case (g)
      2'b01:   return a[ADDR_W-1] & a[ADDR_W-2];
      2'b10:   return a[ADDR_W-1];
      2'b11:   return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  wire [7:0]  byte_in    = {shin_reg[6:0], si_s};
  wire        byte_done  = sck_rise & (bit_cnt_reg == 3'h7);
  wire [7:0]  stat_byte  = {honour_reg, 3'h0, guard_hi_reg, guard_lo_reg, latch_reg, busy_reg};
  wire        pin_block  = honour_reg & wp_low;
  wire [ADDR_W-1:0] waddr = addr_reg[ADDR_W-1:0];
  wire        w_guarded  = guarded(waddr, {guard_hi_reg, guard_lo_reg});
  wire        buf_ready;
  wire        buf_push   = (state_reg == ST_WDATA) & byte_done & latch_reg & ~w_guarded;
  wire        frame_end  = cs_rise & (bit_cnt_reg == 3'h0);
  wire        wen_commit = frame_end & (cmd_reg == OPC_WEN) & ~busy_reg;
  wire        wdis_commit = frame_end & (cmd_reg == OPC_WDIS) & ~busy_reg;
  wire        store_commit = frame_end & (cmd_reg == OPC_STORE) & stat_got_reg
                             & latch_reg & ~pin_block & ~busy_reg;
  wire        write_commit = frame_end & (cmd_reg == OPC_WRITE) & data_got_reg & ~busy_reg;
  wire        cycle_done = busy_reg & (timer_reg == 32'h0) & ~arr_valid;
  wire        rdsr_start = (state_reg == ST_OPC) & byte_done & (byte_in == OPC_RSTAT);

  // Next state after each opcode byte; only status read is served while busy
  always_comb begin
    state_next = state_reg;
    if (!cs_act) begin
      state_next = ST_OPC;
    end else if (byte_done) begin
      case (state_reg)
        ST_OPC: begin
          if (byte_in == OPC_RSTAT) state_next = ST_RSTAT;
          else if (busy_reg) state_next = ST_SKIP;
          else if (byte_in == OPC_WRITE) state_next = ST_ADDR;
          else if (byte_in == OPC_STORE) state_next = ST_WSTAT;
          else state_next = ST_SKIP;
        end
        ST_ADDR:  state_next = addr_cnt_reg ? ST_WDATA : ST_ADDR;
        ST_WSTAT: state_next = ST_SKIP;
        default:  state_next = state_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial shifter and frame tracking
  // ----------------------------------------------------------------
  // Input bits shift in on rising SCK, msb first
  always_ff @(posedge clk) begin
    if (!rstn || !cs_act) begin
      bit_cnt_reg  <= 3'h0;
      shin_reg     <= 8'h00;
      addr_cnt_reg <= 1'b0;
      if (!rstn || !cs_rise) cmd_reg <= 8'h00;  // Kept through select rise only, so an empty frame replays nothing
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shin_reg    <= byte_in;
      if (byte_done && state_reg == ST_OPC) cmd_reg <= byte_in;
      if (byte_done && state_reg == ST_ADDR) addr_cnt_reg <= 1'b1;
    end
  end

  // Address capture and auto increment over data bytes
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_reg     <= 16'h0000;
      data_got_reg <= 1'b0;
      stat_got_reg <= 1'b0;
      stat_new_reg <= 8'h00;
    end else if (!cs_act && !cs_rise) begin
      data_got_reg <= 1'b0;
      stat_got_reg <= 1'b0;
    end else if (byte_done) begin
      if (state_reg == ST_ADDR) addr_reg <= {addr_reg[7:0], byte_in};
      if (state_reg == ST_WDATA) addr_reg <= addr_reg + 16'h0001;
      if (buf_push) data_got_reg <= 1'b1;
      if (state_reg == ST_WSTAT) begin
        stat_got_reg <= 1'b1;
        stat_new_reg <= byte_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) state_reg <= ST_OPC;
    else state_reg <= state_next;
  end

  // Status bytes leave on falling SCK, reloaded each byte so reads repeat
  always_ff @(posedge clk) begin
    if (!rstn) begin
      out_sh_reg <= 8'h00;
      so_reg     <= 1'b0;
    end else if (rdsr_start || (state_reg == ST_RSTAT && byte_done)) begin
      out_sh_reg <= stat_byte;
    end else if (sck_fall && state_reg == ST_RSTAT) begin
      so_reg     <= out_sh_reg[7];
      out_sh_reg <= {out_sh_reg[6:0], 1'b0};
    end
  end

  assign so_out  = so_reg;
  assign so_oe_n = ~(cs_act & (state_reg == ST_RSTAT));

  // ----------------------------------------------------------------
  // Status register and write cycle
  // ----------------------------------------------------------------
  // Persistent bits reload from the store after every reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      honour_reg   <= NV_RESET[2];
      guard_hi_reg <= NV_RESET[1];
      guard_lo_reg <= NV_RESET[0];
      nv_load_reg  <= 1'b1;
      nv_save_reg  <= 1'b0;
    end else begin
      nv_load_reg <= 1'b0;
      nv_save_reg <= store_commit;
      if (nv_load_reg) begin
        {honour_reg, guard_hi_reg, guard_lo_reg} <= nv_init;
      end else if (store_commit) begin
        honour_reg   <= stat_new_reg[BIT_HONOUR];
        guard_hi_reg <= stat_new_reg[BIT_GUARD_HI];
        guard_lo_reg <= stat_new_reg[BIT_GUARD_LO];
      end
    end
  end

  assign nv_save      = nv_save_reg;
  assign nv_save_bits = {honour_reg, guard_hi_reg, guard_lo_reg};

  // Latch clears when a cycle ends, so each write needs a fresh enable
  always_ff @(posedge clk) begin
    if (!rstn) latch_reg <= 1'b0;
    else if (wen_commit) latch_reg <= 1'b1;
    else if (wdis_commit || cycle_done) latch_reg <= 1'b0;
  end

  // Busy ends once the timer is out and the buffer has drained; the pin is not looked at here
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_reg  <= 1'b0;
      timer_reg <= 32'h0;
    end else if (store_commit || write_commit) begin
      busy_reg  <= 1'b1;
      timer_reg <= 32'(CYCLES - 1);
    end else if (busy_reg) begin
      if (timer_reg != 32'h0) timer_reg <= timer_reg - 32'h1;
      if (cycle_done) busy_reg <= 1'b0;
    end
  end

  // Words wait here until the array takes them
  sps_pair_buffer #(
    .W     ($bits(sps_word_t)),
    .DEPTH (2)
  ) u_buf (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (buf_push),
    .in_ready  (buf_ready),
    .in_data   ({waddr, byte_in}),
    .out_valid (arr_valid),
    .out_ready (arr_ready),
    .out_data  (arr_word)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Latch and range checks look at what leaves, not at the terms that gate it
  property p_sample_rise; sck_rise |=> shin_reg[0] == $past(si_s); endproperty
  a_sample_rise: assert property (p_sample_rise) else $error("input bit not taken on rise");
  property p_out_on_fall; $changed(so_reg) |-> $past(sck_fall); endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output moved off a falling edge");
  property p_status_load; rdsr_start |=> out_sh_reg == $past(stat_byte) && out_sh_reg[6:4] == 3'h0; endproperty
  a_status_load: assert property (p_status_load) else $error("status byte not loaded");
  property p_latch_guard; ($rose(arr_valid) || $rose(busy_reg)) |-> $past(latch_reg); endproperty
  a_latch_guard: assert property (p_latch_guard) else $error("write taken without latch");
  property p_range_guard; $rose(arr_valid) |-> !guarded(arr_word.addr, {guard_hi_reg, guard_lo_reg}); endproperty
  a_range_guard: assert property (p_range_guard) else $error("write into guarded range");
  property p_pin_reject;
    (frame_end && cmd_reg == OPC_STORE && honour_reg && wp_low && !nv_load_reg)
    |=> $stable({honour_reg, guard_hi_reg, guard_lo_reg});
  endproperty
  a_pin_reject: assert property (p_pin_reject) else $error("store taken under protect pin");
  property p_busy_start; (store_commit || write_commit) |=> busy_reg [*8]; endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not held after start");
  property p_busy_cause; $rose(busy_reg) |-> $past(store_commit || write_commit); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without a cycle");
  property p_busy_end; $fell(busy_reg) |-> $past(timer_reg) == 32'h0 && !latch_reg; endproperty
  a_busy_end: assert property (p_busy_end) else $error("cycle ended early");
  property p_latch_set; wen_commit |=> latch_reg; endproperty
  a_latch_set: assert property (p_latch_set) else $error("enable did not set latch");
  c_wen:       cover property (wen_commit);
  c_store:     cover property (store_commit);
  c_write:     cover property (write_commit);
  c_stall:     cover property (!buf_ready);
  c_busy_read: cover property (rdsr_start && busy_reg);

endmodule
`default_nettype wire

// File: hdl/sps_pkg.sv
// Shared constants and types of the serial EEPROM status and protection block.
// Assumes a single 25 MHz clock; all SPI pins are asynchronous to it.
package sps_pkg;

  // ----------------------------------------------------------------
  // Array geometry and clock
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 15;
  localparam int          CLK_HZ        = 25_000_000;
  localparam int          WRITE_TIME_MS = 5;
  localparam int          WRITE_CYCLES  = WRITE_TIME_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Command codes and status byte layout
  // ----------------------------------------------------------------
  localparam logic [7:0]  OPC_STORE     = 8'h01; // status_store_cmd
  localparam logic [7:0]  OPC_WRITE     = 8'h02;
  localparam logic [7:0]  OPC_WDIS      = 8'h04;
  localparam logic [7:0]  OPC_RSTAT     = 8'h05;
  localparam logic [7:0]  OPC_WEN       = 8'h06;
  localparam int          BIT_HONOUR    = 7;
  localparam int          BIT_GUARD_HI  = 3;
  localparam int          BIT_GUARD_LO  = 2;
  localparam int          BIT_LATCH     = 1;
  localparam int          BIT_BUSY      = 0;
  localparam logic [2:0]  NV_RESET      = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_OPC   = 6'h01,
    ST_ADDR  = 6'h02,
    ST_WDATA = 6'h04,
    ST_RSTAT = 6'h08,
    ST_WSTAT = 6'h10,
    ST_SKIP  = 6'h20
  } sps_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } sps_word_t;

endpackage

// File: hdl/sps_pair_buffer.sv
// Two-entry valid/ready buffer carrying array write words.
// Assumes both sides run on clk; the drain side may stall at will.
`timescale 1ns/1ps
`default_nettype none
module sps_pair_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0]   count_reg;
  wire           push = in_valid & in_ready;
  wire           pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rptr_reg];

  // Pointer wrap handles non-power-of-two depths
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Pointers and count
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      count_reg <= '0;
    end else begin
      if (push) wptr_reg <= bump(wptr_reg);
      if (pop) rptr_reg <= bump(rptr_reg);
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Data store, no reset needed
  always_ff @(posedge clk) begin
    if (push) mem_reg[wptr_reg] <= in_data;
  end

endmodule
`default_nettype wire

// File: verification/sps_spi_master.sv
// SPI master model that drives the serial pins of the status/protect block.
// Assumes clk is the bench clock; sck runs at 8 clk per period, mode 0 or mode 3.
`timescale 1ns/1ps
`default_nettype none
module sps_spi_master (
  input  wire logic clk,
  output logic      sck,
  output logic      si,
  output logic      chip_select_n,
  input  wire logic so_out
);
  logic cpol; // Idle level of sck: 0 in mode 0, 1 in mode 3
  // ----------------------------------------------------------------
  // Idle state: sck stands still outside frames, low in mode 0 and high in mode 3
  // ----------------------------------------------------------------
  initial begin
    sck           = 1'b0;
    si            = 1'b0;
    chip_select_n = 1'b1;
    cpol          = 1'b0;
  end

  // Change mode only between frames; sck moves to the new idle level
  task automatic set_mode(input logic m);
    @(negedge clk);
    cpol = m;
    sck  = m;
    repeat (4) @(negedge clk);
  endtask

  // Select with setup time before the first sck rise
  task automatic sel();
    @(negedge clk);
    chip_select_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Deselect; si shows the inverse of its last bit so no stale value lingers
  task automatic desel();
    repeat (4) @(negedge clk);
    chip_select_n = 1'b1;
    si            = ~si;
    repeat (6) @(negedge clk);
  endtask

  // One byte, msb first; mode 3 falls before each bit; so is taken just before sck rises
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (cpol) sck = 1'b0;
      si = tx[i];
      repeat (4) @(negedge clk);
      rx[i] = so_out;
      sck   = 1'b1;
      repeat (4) @(negedge clk);
      if (!cpol) sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: verification/sps_status_protect_tb.sv
// Self-checking bench for the status/protect block with an SPI master model.
// Assumes the package opcodes; write timer shortened so busy shows in one read.
`timescale 1ns/1ps
`default_nettype none
module sps_status_protect_tb;
  import sps_pkg::*;
  localparam int CYC = 400;
  logic        clk, rstn, sck, si, chip_select_n, protect_pin_n;
  logic        so_out, so_oe_n, nv_save, arr_valid, arr_ready;
  logic [2:0]  nv_init, nv_save_bits, nv_bits;
  sps_word_t   arr_word;
  logic [22:0] got[$];
  logic [7:0]  s;
  int          n_errors, n_tests, n_nv, cyc;

  sps_status_protect #(.CYCLES(CYC)) sps_status_protect_i (
    .clk(clk), .rstn(rstn), .sck(sck), .si(si), .chip_select_n(chip_select_n),
    .protect_pin_n(protect_pin_n), .so_out(so_out), .so_oe_n(so_oe_n),
    .nv_init(nv_init), .nv_save(nv_save), .nv_save_bits(nv_save_bits),
    .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_word(arr_word));
  // A released output has no pull-up here, so the model sees the inverse of the held bit
  sps_spi_master sps_spi_master_i (
    .clk(clk), .sck(sck), .si(si), .chip_select_n(chip_select_n), .so_out(so_oe_n ? ~so_out : so_out));

  // ----------------------------------------------------------------
  // Clock, monitors and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Collect array words and persistent-store pulses as they happen
  always @(posedge clk) begin
    cyc++;
    if (rstn && arr_valid === 1'b1 && arr_ready) got.push_back(arr_word);
    if (nv_save === 1'b1) begin
      n_nv++;
      nv_bits <= nv_save_bits;
    end
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input logic [22:0] seen, input logic [22:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Frame helpers
  // ----------------------------------------------------------------
  task automatic cmd(input logic [7:0] op);
    logic [7:0] d;
    sps_spi_master_i.sel();
    sps_spi_master_i.xfer(op, d);
    sps_spi_master_i.desel();
  endtask

  task automatic rd(output logic [7:0] v);
    logic [7:0] d;
    sps_spi_master_i.sel();
    sps_spi_master_i.xfer(OPC_RSTAT, d);
    sps_spi_master_i.xfer(8'h00, v);
    sps_spi_master_i.desel();
  endtask

  task automatic store(input logic [7:0] v);
    logic [7:0] d;
    sps_spi_master_i.sel();
    sps_spi_master_i.xfer(OPC_STORE, d);
    sps_spi_master_i.xfer(v, d);
    sps_spi_master_i.desel();
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] d;
    sps_spi_master_i.sel();
    sps_spi_master_i.xfer(OPC_WRITE, d);
    sps_spi_master_i.xfer(a[15:8], d);
    sps_spi_master_i.xfer(a[7:0], d);
    sps_spi_master_i.xfer(d0, d);
    sps_spi_master_i.xfer(d1, d);
    sps_spi_master_i.desel();
  endtask

  // Poll status until the cycle is over, bounded
  task automatic wait_ready();
    for (int i = 0; i < 10; i++) begin
      rd(s);
      if (s[0] === 1'b0) break;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check(so_oe_n, 1'b1);
    rd(s);
    check(s, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_latch();
    cmd(OPC_WEN);
    rd(s);
    check(s, 8'h02);
    cmd(OPC_WDIS);
    rd(s);
    check(s, 8'h00);
    $display("test latch done");
  endtask

  task automatic t_refused();
    store(8'h8c);
    rd(s);
    check(s, 8'h00);
    check(n_nv, 0);
    $display("test refused done");
  endtask

  // Pin low but not honoured: store goes through; disable cannot end busy
  task automatic t_store();
    @(negedge clk) protect_pin_n = 1'b0;
    cmd(OPC_WEN);
    store(8'hf4);
    check(n_nv, 1);
    check(nv_bits, 3'b101);
    cmd(OPC_WDIS);
    rd(s);
    check(s, 8'h87);
    wait_ready();
    check(s, 8'h84);
    $display("test store done");
  endtask

  // Pin low and honoured: store rejected, latch stays set
  task automatic t_pin();
    cmd(OPC_WEN);
    store(8'h80);
    rd(s);
    check(s, 8'h86);
    check(n_nv, 1);
    @(negedge clk) protect_pin_n = 1'b1;
    $display("test pin done");
  endtask

  // Guard 01: top quarter refused; lower write held by a stalled array
  task automatic t_guard();
    @(negedge clk) arr_ready = 1'b0;
    wr(16'h6000, 8'h11, 8'h22);
    wait_ready();
    check(got.size(), 0);
    check(arr_valid, 1'b0);
    cmd(OPC_WEN);
    wr(16'h1ffe, 8'ha5, 8'h3c);
    check(arr_valid, 1'b1);
    @(negedge clk) protect_pin_n = 1'b0;
    repeat (10) @(negedge clk);
    check(got.size(), 0);
    arr_ready = 1'b1;
    repeat (10) @(negedge clk);
    check(got.size(), 2);
    if (got.size() == 2) begin
      check(got[0], {15'h1ffe, 8'ha5});
      check(got[1], {15'h1fff, 8'h3c});
    end
    wait_ready();
    check(s, 8'h84);
    $display("test guard done");
  endtask

  // Mode 3: sck idles high; status read and enable behave as in mode 0
  task automatic t_mode3();
    sps_spi_master_i.set_mode(1'b1);
    rd(s);
    check(s, 8'h84);
    cmd(OPC_WEN);
    rd(s);
    check(s, 8'h86);
    sps_spi_master_i.set_mode(1'b0);
    $display("test mode3 done");
  endtask

  // Power loss with the latch set: latch drops, persistent bits return from the store
  task automatic t_power();
    @(negedge clk);
    rstn    = 1'b0;
    nv_init = nv_bits;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    check(so_oe_n, 1'b1);
    rd(s);
    check(s, 8'h84);
    $display("test power done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn          = 1'b0;
    protect_pin_n = 1'b1;
    nv_init       = NV_RESET;
    arr_ready     = 1'b1;
    nv_bits       = 3'h0;
    n_errors      = 0;
    n_tests       = 0;
    n_nv          = 0;
    cyc           = 0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (6) @(negedge clk);
    t_reset();
    t_latch();
    t_refused();
    t_store();
    t_pin();
    t_guard();
    t_mode3();
    t_power();
    summarize();
  end
endmodule
`default_nettype wire
